// ===== src/rtm_pkg.sv
// Shared constants for the resistive touch matrix controller.
// Assumes one 50 MHz core clock and a register port decoded from the link.
`default_nettype none

package rtm_pkg;
   // ==========================================================
   // Register map and field layout
   localparam logic [6:0] TPCFG_OFFSET = 7'h78;
   localparam int PWR_MSB = 15;
   localparam int PWR_LSB = 14;
   localparam int WAKE_SCOPE_BIT = 13;
   localparam int WIRE_BIT = 12;
   localparam int ISEL_BIT = 8;
   localparam int PU_MSB = 5;
   localparam int PU_LSB = 0;

   // ==========================================================
   // Reset values
   localparam logic [1:0] PWR_RESET = 2'h0;
   localparam logic WAKE_SCOPE_RESET = 1'h0;
   localparam logic WIRE_RESET = 1'h0;
   localparam logic ISEL_RESET = 1'h0;
   localparam logic [5:0] PU_RESET = 6'h01;

   // ==========================================================
   // Digitiser power states
   localparam logic [1:0] PWR_OFF = 2'h0;
   localparam logic [1:0] PWR_WAKE = 2'h1;
   localparam logic [1:0] PWR_FULL = 2'h3;

   // ==========================================================
   // Measurement types
   localparam logic [2:0] MT_X = 3'h1;
   localparam logic [2:0] MT_Y = 3'h2;
   localparam logic [2:0] MT_PRESS = 3'h3;

   // ==========================================================
   // Switch drive codes per contact, sense selector codes
   typedef logic [2:0] rtm_drive_t;
   localparam rtm_drive_t DRV_OPEN = 3'h0;
   localparam rtm_drive_t DRV_SUPPLY = 3'h1;
   localparam rtm_drive_t DRV_GROUND = 3'h2;
   localparam rtm_drive_t DRV_PULLUP = 3'h3;
   localparam rtm_drive_t DRV_ISRC = 3'h4;
   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_RIGHT = 3'h1;
   localparam logic [2:0] SENSE_TOP = 3'h2;
   localparam logic [2:0] SENSE_SHEET = 3'h3;
   localparam logic [2:0] SENSE_AUX1 = 3'h4;
   localparam logic [2:0] SENSE_AUX2 = 3'h5;
   localparam logic [2:0] SENSE_AUX3 = 3'h6;

   // Contact indices; five-wire corners share the same pins
   localparam int NUM_CONTACTS = 5;
   localparam int CT_RIGHT = 0;
   localparam int CT_TOP = 1;
   localparam int CT_LEFT = 2;
   localparam int CT_BOTTOM = 3;
   localparam int CT_SHEET = 4;

   typedef logic [15:0] rtm_word_t;
endpackage : rtm_pkg

`default_nettype wire

// ===== src/rtm_sync_if.sv
// Carrier between the controller and its pin synchroniser.
// Assumes both ends run on core_clk.
`default_nettype none

interface rtm_sync_if;
   logic raw;
   logic level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface : rtm_sync_if

`default_nettype wire

// ===== src/rtm_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to core_clk.
`default_nettype none

module rtm_pin_sync (
   input wire logic core_clk,
   input wire logic reset_n,
   rtm_sync_if.sync port
);
   logic meta_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // ==========================================================
   // Stage one feeds stage two only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         meta_r <= port.raw;
         s2_r <= meta_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
      end
   end

   assign port.level = level_r;
endmodule : rtm_pin_sync

`default_nettype wire

// ===== src/rtm_ctrl.sv
// Touch matrix controller: config register, switch matrix, pen detect, wake.
// Assumes a link decoder presenting register reads and writes on core_clk.
//
// Function
// R1 - 4-wire X: right supply, left ground, sense top
// R2 - 4-wire Y: plates swapped, sense right
// R3 - Touch detect low untouched, high touched
// R4 - Touch detect mirrored to status and interrupt
// R5 - Pressure: constant current, two samples, subtract
// R6 - Bit 8 selects pressure current, 200/400uA
// R7 - 5-wire X: left corners ground, right supply
// R8 - 5-wire Y: bottom corners ground, top supply
// R9 - 5-wire pen detect: corners ground, sheet pull-up
// R10 - Bit 12 selects four or five wire
// R11 - Bits 5:0 divide the pull-up, reset 000001
// R12 - Host never writes pull-up code zero
// R13 - Bits 15:14 set digitiser and detect power
// R14 - State 01 jumps to 11 on pen-down
// R15 - Scope 0: hold link until controller reset
// R16 - Scope 1: wake fully without reset
// R17 - Control only through the register port
// R18 - Measurement type selects matrix configuration
// R19 - Idle matrix stays in pen-detect wiring; code leaves it open in power state 00
`default_nettype none

module rtm_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire rtm_pkg::rtm_word_t reg_wdata,
   input wire logic reg_rd,
   output rtm_pkg::rtm_word_t reg_rdata,
   output logic reg_rd_valid,
   input wire logic link_reset,
   input wire logic sleep_enter,
   input wire logic touch_detect_signal,
   input wire logic meas_active,
   input wire logic [2:0] measurement_type,
   input wire logic adc_done,
   input wire logic [11:0] adc_data,
   output logic [14:0] contact_drive,
   output logic [2:0] sense_sel,
   output logic digitiser_en,
   output logic pen_detect_en,
   output logic pressure_current_sel,
   output logic [5:0] pullup_select,
   output logic panel_wire_count,
   output logic touch_status_bit,
   output logic int_pen_level,
   output logic link_wake_hold,
   output logic device_awake,
   output logic [11:0] pressure_value,
   output logic pressure_valid
);
   import rtm_pkg::*;

   typedef enum logic {PR_PLATE_A, PR_PLATE_B} rtm_press_e;

   // ==========================================================
   // Configuration register
   logic [1:0] pwr_r;
   logic [1:0] pwr_nxt;
   logic wake_scope_r;
   logic wire_r;
   logic isel_r;
   logic [5:0] pu_r;
   logic digitiser_en_r;
   logic pen_detect_en_r;
   rtm_word_t rdata_r;
   logic rd_valid_r;

   wire cfg_hit = (reg_addr == TPCFG_OFFSET);
   wire cfg_wr = reg_wr && cfg_hit; // [R17]
   wire rtm_word_t cfg_word = {pwr_r, wake_scope_r, wire_r, 3'h0, isel_r, 2'h0, pu_r};

   rtm_sync_if pen_if ();
   assign pen_if.raw = touch_detect_signal;
   rtm_pin_sync u_pen_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .port(pen_if.sync)
   );

   logic pen_d_r;
   logic touch_r;
   wire pen_rise = pen_if.level && !pen_d_r && pen_detect_en_r;
   wire wake_fire = (pwr_r == PWR_WAKE) && pen_rise; // [R14]

   // Hardware wake wins over a write in the same cycle
   assign pwr_nxt = wake_fire ? PWR_FULL : (cfg_wr ? reg_wdata[PWR_MSB:PWR_LSB] : pwr_r); // [R14] [R13]

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r <= PWR_RESET;
         wake_scope_r <= WAKE_SCOPE_RESET;
         wire_r <= WIRE_RESET;
         isel_r <= ISEL_RESET;
         pu_r <= PU_RESET;
      end else begin
         pwr_r <= pwr_nxt;
         if (cfg_wr) begin
            wake_scope_r <= reg_wdata[WAKE_SCOPE_BIT];
            wire_r <= reg_wdata[WIRE_BIT]; // [R10]
            isel_r <= reg_wdata[ISEL_BIT]; // [R6]
            // Code zero is reserved; stored as written
            pu_r <= reg_wdata[PU_MSB:PU_LSB]; // [R11] [R12]
         end
      end
   end

   // Power enables follow the state a cycle behind the register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         digitiser_en_r <= 1'b0;
         pen_detect_en_r <= 1'b0;
      end else begin
         digitiser_en_r <= (pwr_r == PWR_FULL); // [R13]
         pen_detect_en_r <= (pwr_r != PWR_OFF); // [R13]
      end
   end

   // Reads answer one cycle later; other addresses read zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= reg_rd;
         if (reg_rd) begin
            rdata_r <= cfg_hit ? cfg_word : 16'h0000; // [R17]
         end
      end
   end

   // ==========================================================
   // Pen detect and wake
   logic hold_r;
   logic awake_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pen_d_r <= 1'b0;
         touch_r <= 1'b0;
      end else begin
         pen_d_r <= pen_if.level;
         touch_r <= pen_if.level && pen_detect_en_r; // [R3] [R4]
      end
   end

   // Set wins over clear for both wake flags
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_r <= 1'b0;
         awake_r <= 1'b1;
      end else begin
         if (wake_fire && !wake_scope_r) begin
            hold_r <= 1'b1; // [R15]
         end else if (link_reset) begin
            hold_r <= 1'b0; // [R15]
         end
         if ((wake_fire && wake_scope_r) || link_reset) begin
            awake_r <= 1'b1; // [R16]
         end else if (sleep_enter) begin
            awake_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pressure sequencer
   rtm_press_e pr_state_r;
   logic [11:0] first_r;
   logic [11:0] press_r;
   logic press_valid_r;
   wire meas_run = meas_active && digitiser_en_r;
   wire press_run = meas_run && !wire_r && (measurement_type == MT_PRESS);
   wire [11:0] press_diff = (first_r >= adc_data) ? (first_r - adc_data) : (adc_data - first_r);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pr_state_r <= PR_PLATE_A;
         first_r <= 12'h000;
         press_r <= 12'h000;
         press_valid_r <= 1'b0;
      end else begin
         press_valid_r <= 1'b0;
         if (!press_run) begin
            pr_state_r <= PR_PLATE_A;
         end else if (adc_done) begin
            unique case (pr_state_r)
               PR_PLATE_A: begin
                  first_r <= adc_data;
                  pr_state_r <= PR_PLATE_B;
               end
               PR_PLATE_B: begin
                  press_r <= press_diff; // [R5]
                  press_valid_r <= 1'b1;
                  pr_state_r <= PR_PLATE_A;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Switch matrix
   logic [NUM_CONTACTS-1:0][2:0] drive_nxt;
   logic [2:0] sense_nxt;
   logic [NUM_CONTACTS-1:0][2:0] drive_r;
   logic [2:0] sense_r;

   always_comb begin
      drive_nxt = '0;
      sense_nxt = SENSE_NONE;
      if (meas_run) begin
         unique case (measurement_type) // [R18]
            MT_X: begin
               if (!wire_r) begin
                  drive_nxt[CT_RIGHT] = DRV_SUPPLY; // [R1]
                  drive_nxt[CT_LEFT] = DRV_GROUND;
                  sense_nxt = SENSE_TOP;
               end else begin
                  drive_nxt[CT_LEFT] = DRV_GROUND; // [R7]
                  drive_nxt[CT_BOTTOM] = DRV_GROUND;
                  drive_nxt[CT_TOP] = DRV_SUPPLY;
                  drive_nxt[CT_RIGHT] = DRV_SUPPLY;
                  sense_nxt = SENSE_SHEET;
               end
            end
            MT_Y: begin
               if (!wire_r) begin
                  drive_nxt[CT_TOP] = DRV_SUPPLY; // [R2]
                  drive_nxt[CT_BOTTOM] = DRV_GROUND;
                  sense_nxt = SENSE_RIGHT;
               end else begin
                  drive_nxt[CT_BOTTOM] = DRV_GROUND; // [R8]
                  drive_nxt[CT_RIGHT] = DRV_GROUND;
                  drive_nxt[CT_LEFT] = DRV_SUPPLY;
                  drive_nxt[CT_TOP] = DRV_SUPPLY;
                  sense_nxt = SENSE_SHEET;
               end
            end
            MT_PRESS: begin
               // Five-wire panels have no pressure path: matrix stays open
               if (!wire_r) begin
                  drive_nxt[CT_RIGHT] = DRV_ISRC; // [R5]
                  drive_nxt[CT_BOTTOM] = DRV_GROUND;
                  sense_nxt = (pr_state_r == PR_PLATE_A) ? SENSE_RIGHT : SENSE_TOP;
               end
            end
            3'h4: sense_nxt = SENSE_AUX1;
            3'h5: sense_nxt = SENSE_AUX2;
            3'h6: sense_nxt = SENSE_AUX3;
            3'h7: sense_nxt = SENSE_SHEET;
            default: sense_nxt = SENSE_NONE;
         endcase
      end else if (pen_detect_en_r) begin
         if (wire_r) begin
            drive_nxt[CT_RIGHT] = DRV_GROUND; // [R9] [R19]
            drive_nxt[CT_TOP] = DRV_GROUND;
            drive_nxt[CT_LEFT] = DRV_GROUND;
            drive_nxt[CT_BOTTOM] = DRV_GROUND;
            drive_nxt[CT_SHEET] = DRV_PULLUP;
         end else begin
            drive_nxt[CT_RIGHT] = DRV_PULLUP; // [R19]
            drive_nxt[CT_BOTTOM] = DRV_GROUND;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_r <= '0;
         sense_r <= SENSE_NONE;
      end else begin
         drive_r <= drive_nxt;
         sense_r <= sense_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = rdata_r;
   assign reg_rd_valid = rd_valid_r;
   assign contact_drive = drive_r;
   assign sense_sel = sense_r;
   assign digitiser_en = digitiser_en_r;
   assign pen_detect_en = pen_detect_en_r;
   assign pressure_current_sel = isel_r; // [R6]
   assign pullup_select = pu_r; // [R11]
   assign panel_wire_count = wire_r; // [R10]
   assign touch_status_bit = touch_r; // [R4]
   assign int_pen_level = touch_r; // [R4]
   assign link_wake_hold = hold_r;
   assign device_awake = awake_r;
   assign pressure_value = press_r;
   assign pressure_valid = press_valid_r;

   // ==========================================================
   // Checks
   a_wake_to_full: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
      (pwr_r == PWR_WAKE && pen_rise) |=> (pwr_r == PWR_FULL) ##1 digitiser_en_r)
      else $error("pen-down in state 01 did not power the digitiser");
   a_link_hold_set: assert property (@(posedge core_clk) disable iff (!reset_n) // [R15]
      (wake_fire && !wake_scope_r) |=> hold_r)
      else $error("link hold not raised on pen wake");
   a_link_hold_keep: assert property (@(posedge core_clk) disable iff (!reset_n) // [R15]
      (hold_r && !link_reset) |=> hold_r)
      else $error("link hold dropped without controller reset");
   a_full_wake: assert property (@(posedge core_clk) disable iff (!reset_n) // [R16]
      (wake_fire && wake_scope_r) |=> (awake_r && $stable(hold_r)))
      else $error("full wake did not wake the device");
   a_touch_gated: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
      !pen_detect_en_r |=> !touch_r)
      else $error("touch reported with detect disabled");
   a_x_four_wire: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
      (meas_run && !wire_r && measurement_type == MT_X) |=>
         (drive_r[CT_RIGHT] == DRV_SUPPLY && drive_r[CT_LEFT] == DRV_GROUND && sense_r == SENSE_TOP))
      else $error("four-wire X matrix wrong");
   a_y_four_wire: assert property (@(posedge core_clk) disable iff (!reset_n) // [R2]
      (meas_run && !wire_r && measurement_type == MT_Y) |=>
         (drive_r[CT_TOP] == DRV_SUPPLY && drive_r[CT_BOTTOM] == DRV_GROUND && sense_r == SENSE_RIGHT))
      else $error("four-wire Y matrix wrong");
   a_x_five_wire: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
      (meas_run && wire_r && measurement_type == MT_X) |=>
         (drive_r[CT_LEFT] == DRV_GROUND && drive_r[CT_BOTTOM] == DRV_GROUND
          && drive_r[CT_TOP] == DRV_SUPPLY && drive_r[CT_RIGHT] == DRV_SUPPLY && sense_r == SENSE_SHEET))
      else $error("five-wire X matrix wrong");
   a_y_five_wire: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
      (meas_run && wire_r && measurement_type == MT_Y) |=>
         (drive_r[CT_BOTTOM] == DRV_GROUND && drive_r[CT_RIGHT] == DRV_GROUND
          && drive_r[CT_LEFT] == DRV_SUPPLY && drive_r[CT_TOP] == DRV_SUPPLY && sense_r == SENSE_SHEET))
      else $error("five-wire Y matrix wrong");
   a_pen_five_wire: assert property (@(posedge core_clk) disable iff (!reset_n) // [R9]
      (!meas_run && pen_detect_en_r && wire_r) |=>
         (drive_r[CT_SHEET] == DRV_PULLUP && drive_r[CT_LEFT] == DRV_GROUND && drive_r[CT_RIGHT] == DRV_GROUND))
      else $error("five-wire pen detect matrix wrong");
   a_press_diff: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
      (press_run && adc_done && pr_state_r == PR_PLATE_B) |=>
         (press_valid_r && press_r == (($past(first_r) >= $past(adc_data)) ?
          ($past(first_r) - $past(adc_data)) : ($past(adc_data) - $past(first_r)))))
      else $error("pressure difference wrong");
endmodule : rtm_ctrl

`default_nettype wire

// ===== src/rtm_dummy_unused.sv
// Empty on purpose.

// ===== verification/rtm_panel_model.sv
// Behavioural resistive panel plus comparator and ADC front end.
// Assumes drive codes of rtm_pkg, contact i in contact_drive[3*i +: 3].
`default_nettype none

module rtm_panel_model (
   input wire logic [14:0] contact_drive,
   input wire logic [2:0] sense_sel,
   input wire logic touched,
   input wire logic [11:0] pos_x,
   input wire logic [11:0] pos_y,
   output logic touch_detect_signal,
   output logic [11:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ns;
   import rtm_pkg::*;
   logic has_pullup;
   logic has_ground;
   logic [11:0] level;
   wire logic x_gradient = contact_drive[3*CT_LEFT +: 3] == DRV_GROUND &&
      contact_drive[3*CT_RIGHT +: 3] == DRV_SUPPLY;

   // ==========================================================
   // Comparator needs a pull-up path closed to ground by the touch
   always_comb begin
      has_pullup = 1'b0;
      has_ground = 1'b0;
      for (int i = 0; i < NUM_CONTACTS; i++) begin
         has_pullup = has_pullup | (contact_drive[3*i +: 3] == DRV_PULLUP);
         has_ground = has_ground | (contact_drive[3*i +: 3] == DRV_GROUND);
      end
   end
   assign touch_detect_signal = touched && has_pullup && has_ground;

   // ==========================================================
   // Sensed voltage; an untouched plate floats, so show the inverse
   always_comb begin
      case (sense_sel)
         SENSE_TOP: level = pos_x;
         SENSE_RIGHT: level = pos_y;
         SENSE_SHEET: level = x_gradient ? pos_x : pos_y;
         default: level = pos_x ^ pos_y;
      endcase
   end
   assign adc_data = touched ? level : ~level;
endmodule : rtm_panel_model

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the touch matrix controller.
// Assumes rtm_pkg and the panel model are compiled before it.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rtm_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr, reg_rd, link_reset, sleep_enter, meas_active, adc_done, touched;
   logic [6:0] reg_addr;
   logic [2:0] measurement_type, sense_sel;
   rtm_word_t reg_wdata, reg_rdata, w;
   logic [11:0] adc_data, pressure_value, pos_x, pos_y;
   logic [14:0] contact_drive;
   logic [14:0] exp_drive [4];
   logic [5:0] pullup_select;
   logic touch_detect_signal, reg_rd_valid, digitiser_en, pen_detect_en, pressure_current_sel;
   logic panel_wire_count, touch_status_bit, int_pen_level, link_wake_hold, device_awake, pressure_valid;
   int n_mismatch = 0;
   int n_compared = 0;
   integer seed = 4929;
   rtm_word_t exp_q [$];

   always #10 core_clk = ~core_clk;

   rtm_ctrl uut (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rd_valid,
      .link_reset, .sleep_enter, .touch_detect_signal, .meas_active, .measurement_type, .adc_done,
      .adc_data, .contact_drive, .sense_sel, .digitiser_en, .pen_detect_en, .pressure_current_sel,
      .pullup_select, .panel_wire_count, .touch_status_bit, .int_pen_level, .link_wake_hold,
      .device_awake, .pressure_value, .pressure_valid);

   rtm_panel_model panel (.contact_drive, .sense_sel, .touched, .pos_x, .pos_y, .touch_detect_signal,
      .adc_data);

   // ==========================================================
   // Shared tasks
   task automatic tick;
      @(posedge core_clk);
      #2;
   endtask : tick

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
      n_compared++;
      if (seen !== expv) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask : check

   // Strobe dropped a cycle later so back-to-back calls never touch it twice at once
   task automatic wr(input logic [6:0] a, input rtm_word_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      tick;
   endtask : wr

   task automatic rd(input logic [6:0] a, input rtm_word_t e);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(e);
      tick;
      reg_rd = 1'b0;
      tick;
   endtask : rd

   task automatic set_meas(input logic act, input logic [2:0] t);
      meas_active = act;
      measurement_type = t;
      repeat (3) tick;
   endtask : set_meas

   task automatic wait_status(input logic lvl);
      for (int k = 0; k < 30 && touch_status_bit !== lvl; k++) tick;
      check("touch_status_bit", 16'(touch_status_bit), 16'(lvl));
   endtask : wait_status

   function automatic logic [14:0] pack(input rtm_drive_t r, t, l, b, s);
      return {s, b, l, t, r};
   endfunction : pack

   task automatic results;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   // ==========================================================
   // Result monitor: reads and pressure results never overlap
   always @(posedge core_clk) begin
      if (reg_rd_valid === 1'b1) check("reg_rdata", reg_rdata, exp_q.pop_front());
      if (pressure_valid === 1'b1) check("pressure_value", 16'(pressure_value), exp_q.pop_front());
   end

   initial begin
      repeat (4000) @(posedge core_clk);
      n_mismatch++;
      results;
   end

   // ==========================================================
   // Main sequence
   initial begin
      {reg_wr, reg_rd, link_reset, sleep_enter, meas_active, adc_done, touched} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      measurement_type = '0;
      pos_x = 12'($random(seed));
      pos_y = 12'($random(seed));
      exp_drive[0] = pack(DRV_SUPPLY, DRV_OPEN, DRV_GROUND, DRV_OPEN, DRV_OPEN);
      exp_drive[1] = pack(DRV_OPEN, DRV_SUPPLY, DRV_OPEN, DRV_GROUND, DRV_OPEN);
      exp_drive[2] = pack(DRV_SUPPLY, DRV_SUPPLY, DRV_GROUND, DRV_GROUND, DRV_OPEN);
      exp_drive[3] = pack(DRV_GROUND, DRV_SUPPLY, DRV_SUPPLY, DRV_GROUND, DRV_OPEN);
      repeat (10) @(posedge core_clk);
      #2;
      reset_n = 1'b1;
      rd(TPCFG_OFFSET, 16'h0001);
      check("pullup_select", 16'(pullup_select), 16'h0001);
      wr(7'h76, 16'hFFFF);
      rd(TPCFG_OFFSET, 16'h0001);
      rd(7'h7A, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         w = 16'($random(seed));
         if (w[PU_MSB:PU_LSB] == 6'h00) w[PU_LSB] = 1'b1;
         wr(TPCFG_OFFSET, w);
         rd(TPCFG_OFFSET, w & 16'hF13F);
         check("pullup_select", 16'(pullup_select), 16'(w[PU_MSB:PU_LSB]));
         check("panel_wire_count", 16'(panel_wire_count), 16'(w[WIRE_BIT]));
         check("pressure_current_sel", 16'(pressure_current_sel), 16'(w[ISEL_BIT]));
         check("pen_detect_en", 16'(pen_detect_en), 16'(w[PWR_MSB:PWR_LSB] != PWR_OFF));
         check("digitiser_en", 16'(digitiser_en), 16'(w[PWR_MSB:PWR_LSB] == PWR_FULL));
      end
      for (int i = 0; i < 4; i++) begin
         wr(TPCFG_OFFSET, 16'hC001 | (16'(i >> 1) << WIRE_BIT));
         set_meas(1'b1, i[0] ? MT_Y : MT_X);
         check("contact_drive", 16'(contact_drive), 16'(exp_drive[i]));
         check("sense_sel", 16'(sense_sel), i == 0 ? 16'(SENSE_TOP) : i == 1 ? 16'(SENSE_RIGHT) :
            16'(SENSE_SHEET));
      end
      for (int t = 4; t < 8; t++) begin
         set_meas(1'b1, 3'(t));
         check("sense_sel", 16'(sense_sel), t == 7 ? 16'(SENSE_SHEET) : 16'(t));
      end
      // Active run with no measurement type leaves the matrix open
      set_meas(1'b1, 3'h0);
      check("sense_sel", 16'(sense_sel), 16'(SENSE_NONE));
      check("contact_drive", 16'(contact_drive), 16'h0000);
      set_meas(1'b0, 3'h0);
      check("contact_drive", 16'(contact_drive), 16'(pack(DRV_GROUND, DRV_GROUND, DRV_GROUND, DRV_GROUND,
         DRV_PULLUP)));
      wr(TPCFG_OFFSET, 16'h8001);
      repeat (3) tick;
      check("contact_drive", 16'(contact_drive), 16'(pack(DRV_PULLUP, DRV_OPEN, DRV_OPEN, DRV_GROUND,
         DRV_OPEN)));
      wr(TPCFG_OFFSET, 16'h0001);
      repeat (3) tick;
      check("contact_drive", 16'(contact_drive), 16'h0000);
      // Pressure: two plate samples, difference reported
      touched = 1'b1;
      wr(TPCFG_OFFSET, 16'hC101);
      set_meas(1'b1, MT_PRESS);
      check("contact_drive", 16'(contact_drive), 16'(pack(DRV_ISRC, DRV_OPEN, DRV_OPEN, DRV_GROUND,
         DRV_OPEN)));
      check("sense_sel", 16'(sense_sel), 16'(SENSE_RIGHT));
      adc_done = 1'b1;
      tick;
      adc_done = 1'b0;
      for (int k = 0; k < 20 && sense_sel !== SENSE_TOP; k++) tick;
      exp_q.push_back(16'(pos_y > pos_x ? pos_y - pos_x : pos_x - pos_y));
      adc_done = 1'b1;
      tick;
      adc_done = 1'b0;
      repeat (3) tick;
      wr(TPCFG_OFFSET, 16'hD001);
      repeat (3) tick;
      check("contact_drive", 16'(contact_drive), 16'h0000);
      touched = 1'b0;
      // Pen-down wake of the link only, released by a link reset
      wr(TPCFG_OFFSET, 16'h4001);
      set_meas(1'b0, 3'h0);
      wait_status(1'b0);
      touched = 1'b1;
      wait_status(1'b1);
      check("int_pen_level", 16'(int_pen_level), 16'h0001);
      check("link_wake_hold", 16'(link_wake_hold), 16'h0001);
      rd(TPCFG_OFFSET, 16'hC001);
      link_reset = 1'b1;
      tick;
      link_reset = 1'b0;
      tick;
      check("link_wake_hold", 16'(link_wake_hold), 16'h0000);
      touched = 1'b0;
      wait_status(1'b0);
      // Full wake from sleep
      sleep_enter = 1'b1;
      tick;
      sleep_enter = 1'b0;
      tick;
      check("device_awake", 16'(device_awake), 16'h0000);
      wr(TPCFG_OFFSET, 16'h6001);
      touched = 1'b1;
      wait_status(1'b1);
      check("device_awake", 16'(device_awake), 16'h0001);
      check("link_wake_hold", 16'(link_wake_hold), 16'h0000);
      rd(TPCFG_OFFSET, 16'hE001);
      touched = 1'b0;
      wait_status(1'b0);
      // Detect-only state never wakes
      wr(TPCFG_OFFSET, 16'h8001);
      touched = 1'b1;
      wait_status(1'b1);
      rd(TPCFG_OFFSET, 16'h8001);
      touched = 1'b0;
      repeat (5) tick;
      // Mid-run reset after sleep restores awake and register defaults
      sleep_enter = 1'b1;
      tick;
      sleep_enter = 1'b0;
      reset_n = 1'b0;
      tick;
      reset_n = 1'b1;
      check("device_awake", 16'(device_awake), 16'h0001);
      rd(TPCFG_OFFSET, 16'h0001);
      check("pen_detect_en", 16'(pen_detect_en), 16'h0000);
      results;
   end
endmodule : tb_top

`default_nettype wire
